// ---- sim/dual_bus_config_space_bench.sv ----
// Self-checking bench for the configuration space block
`timescale 1ns/1ps
module dual_bus_config_space_bench;
   import cfg_space_pkg::*;
   logic        sys_clk, rst_n, cfg_sel, cfg_wr, cfg_rd, mem_rd, mem_wr, mem_hit, io_hit;
   logic        addr_phase, data_phase, func_irq, alt_irq_clear, bad_par, bus_par;
   logic        perr_o, perr_oe, serr_o, serr_oe, int_n, card_status_change_signal, reset_done;
   logic [5:0]  cfg_idx;
   logic [3:0]  cfg_be, bus_cbe;
   logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, io_addr, bus_ad;
   logic [15:0] seed;
   logic [31:0] exp_q[$];
   int          error_cnt, n_tests;
   dual_bus_config_space u_dut (.sys_clk, .rst_n, .cfg_sel, .cfg_wr, .cfg_rd, .cfg_idx, .cfg_be, .cfg_wdata,
      .cfg_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_hit, .io_hit, .io_addr, .addr_phase,
      .data_phase, .bus_ad, .bus_cbe, .bus_par, .func_irq, .alt_irq_clear, .perr_o, .perr_oe, .serr_o,
      .serr_oe, .int_n, .card_status_change_signal, .reset_done);
   host_bridge_model u_host (.bus_ad, .bus_cbe, .bad_par, .bus_par);
   // ==========================================
   // Clock, watchdog, helpers
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg(input logic wr, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      cfg_sel <= 1'b1;
      cfg_wr <= wr;
      cfg_rd <= !wr;
      cfg_idx <= idx;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge sys_clk);
      cfg_sel <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      #1;
   endtask
   task automatic mem(input logic wr, input logic [11:0] off, input logic [31:0] d);
      @(posedge sys_clk);
      mem_wr <= wr;
      mem_rd <= !wr;
      mem_addr <= {20'h10000, off};
      mem_wdata <= d;
      @(posedge sys_clk);
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      #1;
   endtask
   task automatic phase(input logic a, input logic bad);
      @(posedge sys_clk);
      addr_phase <= a;
      data_phase <= !a;
      bus_ad <= {seed, lfsr(seed)};
      bus_cbe <= seed[3:0];
      bad_par <= bad;
      seed = lfsr(lfsr(seed));
      @(posedge sys_clk);
      addr_phase <= 1'b0;
      data_phase <= 1'b0;
      @(posedge sys_clk);
      #1;
      check(a ? "serr_oe" : "perr_oe", {31'h0, bad}, {31'h0, a ? serr_oe : perr_oe});
      check("error pin levels", 32'h0, {30'h0, perr_o, serr_o});
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {rst_n, cfg_sel, cfg_wr, cfg_rd, mem_rd, mem_wr, addr_phase, data_phase, func_irq} = '0;
      {alt_irq_clear, bad_par, cfg_idx, cfg_be, bus_cbe, cfg_wdata, mem_addr, mem_wdata, bus_ad} = '0;
      io_addr = 32'h0;
      seed = 16'h002c;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("reset_done early", 32'h0, {31'h0, reset_done});
      repeat (98) @(posedge sys_clk);
      #1;
      check("reset_done", 32'h1, {31'h0, reset_done});
      cfg(1'b0, CFG_IDX_CMDSTAT, 4'hf, 32'h0);
      check("cmd after reset", 32'h0, cfg_rdata & 32'hc000_0143);
      exp_q = '{32'h5678_1234, 32'hff00_0001, 32'h0101_0100, 32'h0000_0801, 32'h0};
      foreach (exp_q[i]) begin
         cfg(1'b0, i == 0 ? CFG_IDX_ID : i == 1 ? CFG_IDX_CLASS : i == 2 ? CFG_IDX_MISC
                   : i == 3 ? CFG_IDX_INF_PTR : 6'h20, 4'hf, 32'h0);
         check("header", exp_q[i], cfg_rdata);
      end
      cfg(1'b1, CFG_IDX_BAR_MEM, 4'hf, 32'hffff_ffff);
      cfg(1'b0, CFG_IDX_BAR_MEM, 4'hf, 32'h0);
      check("mem bar size", 32'hffff_f000, cfg_rdata);
      cfg(1'b1, CFG_IDX_BAR_IO, 4'hf, 32'hffff_ffff);
      cfg(1'b0, CFG_IDX_BAR_IO, 4'hf, 32'h0);
      check("io bar size", 32'hffff_fff0 | BAR_IO_TYPE, cfg_rdata);
      cfg(1'b1, CFG_IDX_BAR_MEM, 4'hf, 32'h1000_0000);
      cfg(1'b1, CFG_IDX_BAR_IO, 4'hf, 32'h0000_0100);
      cfg(1'b1, CFG_IDX_CMDSTAT, 4'h3, 32'h0000_0143);
      cfg(1'b0, CFG_IDX_CMDSTAT, 4'hf, 32'h0);
      check("cmd enables", 32'h0000_0143, cfg_rdata & 32'h0000_0143);
      @(posedge sys_clk);
      io_addr <= 32'h0000_0104;
      #1;
      check("io_hit", 32'h1, {31'h0, io_hit});
      mem(1'b1, SC_OFF_MASK, 32'h1 << SC_IRQ_BIT);
      mem(1'b1, SC_OFF_FORCE, 32'h1 << SC_IRQ_BIT);
      repeat (3) @(posedge sys_clk);
      #1;
      check("status change", 32'h1, {31'h0, card_status_change_signal & !int_n});
      mem(1'b0, SC_OFF_EVENT, 32'h0);
      check("event", 32'h1 << SC_IRQ_BIT, mem_rdata & (32'h1 << SC_IRQ_BIT));
      mem(1'b0, SC_OFF_MASK, 32'h0);
      check("mask", 32'h1 << SC_IRQ_BIT, mem_rdata & (32'h1 << SC_IRQ_BIT));
      mem(1'b1, SC_OFF_EVENT, 32'h1 << SC_IRQ_BIT);
      repeat (2) @(posedge sys_clk);
      #1;
      check("int_n cleared", 32'h1, {31'h0, int_n});
      mem(1'b0, SC_OFF_INF, 32'h0);
      check("structure hit", 32'h1, {31'h0, mem_hit});
      cfg(1'b1, CFG_IDX_IRQCTL, 4'h1, 32'h1);
      mem(1'b1, SC_OFF_FORCE, 32'h1 << SC_IRQ_BIT);
      mem(1'b1, SC_OFF_EVENT, 32'h1 << SC_IRQ_BIT);
      repeat (2) @(posedge sys_clk);
      #1;
      check("clear refused", 32'h0, {31'h0, int_n});
      @(posedge sys_clk);
      alt_irq_clear <= 1'b1;
      @(posedge sys_clk);
      alt_irq_clear <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      check("alt clear", 32'h1, {31'h0, int_n});
      @(posedge sys_clk);
      func_irq <= 1'b1;
      alt_irq_clear <= 1'b1;
      @(posedge sys_clk);
      alt_irq_clear <= 1'b0;
      mem(1'b0, SC_OFF_PRES, 32'h0);
      check("present", 32'h1 << SC_IRQ_BIT, mem_rdata);
      check("set wins", 32'h0, {31'h0, int_n});
      @(posedge sys_clk);
      func_irq <= 1'b0;
      alt_irq_clear <= 1'b1;
      @(posedge sys_clk);
      alt_irq_clear <= 1'b0;
      #1;
      check("func clear", 32'h1, {31'h0, int_n});
      phase(1'b1, 1'b0);
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      cfg(1'b0, CFG_IDX_CMDSTAT, 4'hf, 32'h0);
      check("error flags", 32'hc000_0000, cfg_rdata & 32'hc000_0000);
      cfg(1'b1, CFG_IDX_CMDSTAT, 4'h8, 32'hc000_0000);
      cfg(1'b0, CFG_IDX_CMDSTAT, 4'hf, 32'h0);
      check("flags cleared", 32'h0, cfg_rdata & 32'hc000_0000);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      cfg(1'b0, CFG_IDX_CMDSTAT, 4'hf, 32'h0);
      check("cmd second reset", 32'h0, cfg_rdata & 32'h0000_0143);
      print_verdict();
   end
endmodule

// ---- sim/dual_bus_config_space_monitor.sv ----
// Port checker for the configuration space block
`timescale 1ns/1ps
module dual_bus_config_space_monitor
   import cfg_space_pkg::*;
#(
   parameter logic [15:0] MAKER_ID  = 16'h1234,
   parameter logic [15:0] DEVICE_ID = 16'h5678
) (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        cfg_sel,
   input wire logic        cfg_rd,
   input wire logic [5:0]  cfg_idx,
   input wire logic [31:0] cfg_rdata,
   input wire logic        addr_phase,
   input wire logic        data_phase,
   input wire logic [31:0] bus_ad,
   input wire logic [3:0]  bus_cbe,
   input wire logic        bus_par,
   input wire logic        perr_o,
   input wire logic        perr_oe,
   input wire logic        serr_o,
   input wire logic        serr_oe,
   input wire logic        int_n,
   input wire logic        card_status_change_signal,
   input wire logic        reset_done
);
   // ==========================================
   // Helpers
   logic       rd_go;
   logic       addr_bad;
   logic       data_bad;
   logic [6:0] clk_cnt_r;
   assign rd_go    = cfg_sel & cfg_rd;
   assign addr_bad = addr_phase & (^{bus_ad, bus_cbe, bus_par});
   assign data_bad = data_phase & (^{bus_ad, bus_cbe, bus_par});
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) clk_cnt_r <= 7'h00;
      else if (clk_cnt_r != 7'h7f) clk_cnt_r <= clk_cnt_r + 7'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Assertions
   a_id_read: assert property (rd_go && cfg_idx == CFG_IDX_ID |=> cfg_rdata == {DEVICE_ID, MAKER_ID})
      else $error("identity read wrong");
   a_info_ptr: assert property (rd_go && cfg_idx == CFG_IDX_INF_PTR |=> cfg_rdata == 32'h0000_0801)
      else $error("structure pointer wrong");
   a_rdata_hold: assert property (!rd_go |=> $stable(cfg_rdata))
      else $error("read data moved without read");
   a_csc_int: assert property (card_status_change_signal |-> !int_n)
      else $error("status change without interrupt");
   a_perr_low: assert property (perr_oe |-> !perr_o)
      else $error("parity pin not driven low");
   a_serr_low: assert property (serr_oe |-> !serr_o)
      else $error("system error pin not driven low");
   a_perr_cause: assert property (perr_oe |-> $past(data_bad, 2))
      else $error("parity error without bad data phase");
   a_serr_cause: assert property (serr_oe |-> $past(addr_bad, 2))
      else $error("system error without bad address phase");
   a_reset_time: assert property (clk_cnt_r >= 7'h64 |-> reset_done)
      else $error("internal reset too slow");
   c_serr: cover property (addr_bad ##2 serr_oe);
   c_perr: cover property (data_bad ##2 perr_oe);
   c_csc: cover property (card_status_change_signal);
endmodule
bind dual_bus_config_space dual_bus_config_space_monitor #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) u_mon (
   .sys_clk, .rst_n, .cfg_sel, .cfg_rd, .cfg_idx, .cfg_rdata, .addr_phase, .data_phase, .bus_ad,
   .bus_cbe, .bus_par, .perr_o, .perr_oe, .serr_o, .serr_oe, .int_n, .card_status_change_signal, .reset_done);

// ---- sim/host_bridge_model.sv ----
// Host bridge model: drives bus parity for address and data phases
`timescale 1ns/1ps
module host_bridge_model (
   input  wire logic [31:0] bus_ad,
   input  wire logic [3:0]  bus_cbe,
   input  wire logic        bad_par,
   output logic             bus_par
);
   // ==========================================
   // Even parity, inverted only when a fault is commanded
   assign bus_par = ^{bus_ad, bus_cbe} ^ bad_par;
endmodule

// ---- verilog/cfg_space_pkg.sv ----
// Package: configuration header layout, command/status bits, status-change fields
package cfg_space_pkg;
   // ==========================================
   // Configuration dword indices (byte address / 4)
   localparam logic [5:0] CFG_IDX_ID      = 6'h00;
   localparam logic [5:0] CFG_IDX_CMDSTAT = 6'h01;
   localparam logic [5:0] CFG_IDX_CLASS   = 6'h02;
   localparam logic [5:0] CFG_IDX_MISC    = 6'h03;
   localparam logic [5:0] CFG_IDX_BAR_MEM = 6'h04;
   localparam logic [5:0] CFG_IDX_BAR_IO  = 6'h05;
   localparam logic [5:0] CFG_IDX_INF_PTR = 6'h0a;
   localparam logic [5:0] CFG_IDX_IRQCTL  = 6'h0f;
   // ==========================================
   // Command register bits
   localparam int CMD_IO_EN   = 0;
   localparam int CMD_MEM_EN  = 1;
   localparam int CMD_PERR_EN = 6;
   localparam int CMD_SERR_EN = 8;
   // Status register bits (upper half of dword 1)
   localparam int STAT_SIG_SERR = 30;
   localparam int STAT_DET_PERR = 31;
   // BAR type bits
   localparam logic [31:0] BAR_IO_TYPE = 32'h0000_0001;
   // ==========================================
   // Status-change register offsets within memory BAR (bytes)
   localparam logic [11:0] SC_OFF_EVENT = 12'h000;
   localparam logic [11:0] SC_OFF_MASK  = 12'h004;
   localparam logic [11:0] SC_OFF_FORCE = 12'h008;
   localparam logic [11:0] SC_OFF_PRES  = 12'h00c;
   localparam logic [11:0] SC_OFF_INF   = 12'h800;
   localparam int          SC_IRQ_BIT   = 15;
   // ==========================================
   // Reset timing
   localparam int RESET_CLOCKS = 100;
endpackage

// ---- verilog/dual_bus_config_space.sv ----
// Dual-bus configuration space, command/status, BARs and status-change registers
`timescale 1ns/1ps
module dual_bus_config_space #(
   parameter logic [15:0] MAKER_ID   = 16'h1234, // Arbitrary value
   parameter logic [15:0] DEVICE_ID  = 16'h5678, // Arbitrary value
   parameter logic [7:0]  REVISION   = 8'h01,    // Arbitrary value
   parameter logic [23:0] CLASS_CODE = 24'hff0000,
   parameter logic [7:0]  MIN_GRANT  = 8'h01,
   parameter logic [7:0]  MAX_LAT    = 8'h01,
   parameter int          MEM_BAR_BITS = 12,
   parameter int          IO_BAR_BITS  = 4,
   parameter int          INF_WORDS    = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        cfg_sel,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [5:0]  cfg_idx,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic [31:0]      mem_rdata,
   output logic             mem_hit,
   output logic             io_hit,
   input  wire logic [31:0] io_addr,
   input  wire logic        addr_phase,
   input  wire logic        data_phase,
   input  wire logic [31:0] bus_ad,
   input  wire logic [3:0]  bus_cbe,
   input  wire logic        bus_par,
   input  wire logic        func_irq,
   input  wire logic        alt_irq_clear,
   output logic             perr_o,
   output logic             perr_oe,
   output logic             serr_o,
   output logic             serr_oe,
   output logic             int_n,
   output logic             card_status_change_signal,
   output logic             reset_done
);
   import cfg_space_pkg::*;

   // ==========================================
   // Reset sequencing
   logic [6:0] rst_cnt_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cnt_r <= 7'h00;
      end else if (rst_cnt_r != 7'(RESET_CLOCKS - 1)) begin
         rst_cnt_r <= rst_cnt_r + 7'h01;
      end
   end
   assign reset_done = (rst_cnt_r == 7'(RESET_CLOCKS - 1));

   // ==========================================
   // Command and status
   logic       io_en_r, mem_en_r, perr_en_r, serr_en_r;
   logic       sig_serr_r, det_perr_r;
   logic [7:0] int_line_r;
   logic       sc_disable_r;
   logic       cmd_wr, misc_wr, irq_wr;
   logic       addr_err, data_err;
   logic       ap_d, dp_d;

   assign cmd_wr  = cfg_sel & cfg_wr & (cfg_idx == CFG_IDX_CMDSTAT);
   assign misc_wr = cfg_sel & cfg_wr & (cfg_idx == CFG_IDX_MISC);
   assign irq_wr  = cfg_sel & cfg_wr & (cfg_idx == CFG_IDX_IRQCTL);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_en_r   <= 1'b0;
         mem_en_r  <= 1'b0;
         perr_en_r <= 1'b0;
         serr_en_r <= 1'b0;
      end else if (cmd_wr) begin
         if (cfg_be[0]) begin
            io_en_r   <= cfg_wdata[CMD_IO_EN];
            mem_en_r  <= cfg_wdata[CMD_MEM_EN];
            perr_en_r <= cfg_wdata[CMD_PERR_EN];
         end
         if (cfg_be[1]) begin
            serr_en_r <= cfg_wdata[CMD_SERR_EN];
         end
      end
   end

   // Parity checking of address and data phases
   parity_check u_addr_chk (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .chk_en  (addr_phase),
      .ad      (bus_ad),
      .cbe     (bus_cbe),
      .par     (bus_par),
      .err_r   (addr_err)
   );
   parity_check u_data_chk (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .chk_en  (data_phase),
      .ad      (bus_ad),
      .cbe     (bus_cbe),
      .par     (bus_par),
      .err_r   (data_err)
   );
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_d <= 1'b0;
         dp_d <= 1'b0;
      end else begin
         ap_d <= addr_phase;
         dp_d <= data_phase;
      end
   end

   // Error flags: set wins over write-one-clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         det_perr_r <= 1'b0;
         sig_serr_r <= 1'b0;
      end else begin
         if (addr_err | data_err) begin
            det_perr_r <= 1'b1;
         end else if (cmd_wr && cfg_be[3] && cfg_wdata[STAT_DET_PERR]) begin
            det_perr_r <= 1'b0;
         end
         if (addr_err & serr_en_r & perr_en_r) begin
            sig_serr_r <= 1'b1;
         end else if (cmd_wr && cfg_be[3] && cfg_wdata[STAT_SIG_SERR]) begin
            sig_serr_r <= 1'b0;
         end
      end
   end

   // Error pins, open-drain style
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         perr_oe <= 1'b0;
         serr_oe <= 1'b0;
      end else begin
         perr_oe <= data_err & dp_d & perr_en_r;
         serr_oe <= addr_err & ap_d & perr_en_r & serr_en_r;
      end
   end
   assign perr_o = 1'b0;
   assign serr_o = 1'b0;

   // ==========================================
   // Interrupt line and alternative clearing control
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_line_r <= 8'h00;
      end else if (misc_wr && cfg_be[0]) begin
         int_line_r <= cfg_wdata[7:0];
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sc_disable_r <= 1'b0;
      end else if (irq_wr && cfg_be[0]) begin
         sc_disable_r <= cfg_wdata[0];
      end
   end

   // ==========================================
   // Base address registers
   logic [31:MEM_BAR_BITS] mem_base_r;
   logic [31:IO_BAR_BITS]  io_base_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_base_r <= '0;
         io_base_r  <= '0;
      end else if (cfg_sel && cfg_wr && cfg_be == 4'hf) begin
         if (cfg_idx == CFG_IDX_BAR_MEM) begin
            mem_base_r <= cfg_wdata[31:MEM_BAR_BITS];
         end
         if (cfg_idx == CFG_IDX_BAR_IO) begin
            io_base_r <= cfg_wdata[31:IO_BAR_BITS];
         end
      end
   end
   assign mem_hit = mem_en_r & (mem_addr[31:MEM_BAR_BITS] == mem_base_r);
   assign io_hit  = io_en_r & (io_addr[31:IO_BAR_BITS] == io_base_r);

   // ==========================================
   // Status-change registers
   logic sc_event_r, sc_mask_r, sc_force_r;
   logic [11:0] moff;
   logic sc_wr;
   assign moff  = mem_addr[11:0];
   assign sc_wr = mem_wr & mem_hit;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sc_event_r <= 1'b0;
         sc_mask_r  <= 1'b0;
         sc_force_r <= 1'b0;
      end else begin
         sc_force_r <= sc_wr && moff == SC_OFF_FORCE && mem_wdata[SC_IRQ_BIT];
         if (func_irq | sc_force_r) begin
            sc_event_r <= 1'b1;
         end else if (sc_disable_r ? alt_irq_clear
                                   : (sc_wr && moff == SC_OFF_EVENT && mem_wdata[SC_IRQ_BIT])) begin
            sc_event_r <= 1'b0;
         end
         if (sc_wr && moff == SC_OFF_MASK) begin
            sc_mask_r <= mem_wdata[SC_IRQ_BIT];
         end
      end
   end
   assign card_status_change_signal = sc_event_r & sc_mask_r;
   assign int_n = ~sc_event_r;

   // ==========================================
   // Card information structure storage
   logic [31:0] inf_mem [INF_WORDS];
   always_comb begin
      for (int i = 0; i < INF_WORDS; i++) begin
         inf_mem[i] = {16'h0000, 8'(i), 8'(i)};
      end
   end

   // ==========================================
   // Read paths
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (cfg_sel && cfg_rd) begin
         unique case (cfg_idx)
            CFG_IDX_ID:      cfg_rdata <= {DEVICE_ID, MAKER_ID};
            CFG_IDX_CMDSTAT: cfg_rdata <= {det_perr_r, sig_serr_r, 14'h0000, 7'h00, serr_en_r,
                                          1'b0, perr_en_r, 4'h0, mem_en_r, io_en_r};
            CFG_IDX_CLASS:   cfg_rdata <= {CLASS_CODE, REVISION};
            CFG_IDX_MISC:    cfg_rdata <= {MAX_LAT, MIN_GRANT, 8'h01, int_line_r};
            CFG_IDX_BAR_MEM: cfg_rdata <= {mem_base_r, {MEM_BAR_BITS{1'b0}}};
            CFG_IDX_BAR_IO:  cfg_rdata <= {io_base_r, IO_BAR_BITS'(BAR_IO_TYPE)};
            CFG_IDX_INF_PTR: cfg_rdata <= {20'h00000, SC_OFF_INF} | 32'h0000_0001;
            CFG_IDX_IRQCTL:  cfg_rdata <= {31'h0000_0000, sc_disable_r};
            default:         cfg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= 32'h0000_0000;
      end else if (mem_rd && mem_hit) begin
         if (moff >= SC_OFF_INF) begin
            mem_rdata <= inf_mem[moff[$clog2(INF_WORDS)+1:2]];
         end else begin
            unique case (moff)
               SC_OFF_EVENT: mem_rdata <= 32'(sc_event_r) << SC_IRQ_BIT;
               SC_OFF_MASK:  mem_rdata <= 32'(sc_mask_r) << SC_IRQ_BIT;
               SC_OFF_FORCE: mem_rdata <= 32'h0000_0000;
               SC_OFF_PRES:  mem_rdata <= 32'(func_irq) << SC_IRQ_BIT;
               default:      mem_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ---- verilog/parity_check.sv ----
// Even parity checker for one address or data phase
`timescale 1ns/1ps
module parity_check (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        chk_en,
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cbe,
   input  wire logic        par,
   output logic             err_r
);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else begin
         err_r <= chk_en & ((^ad) ^ (^cbe) ^ par);
      end
   end
endmodule
